// File: hdl/pvs_pkg.sv
package pvs_pkg;
  // register file shape
  localparam int unsigned REG_W       = 12;
  localparam int unsigned REG_NUM     = 19;
  localparam int unsigned ADDR_W      = 5;
  // register indices (load address)
  localparam logic [4:0] STATUS_MODE_CONTROL     = 5'h00;
  localparam logic [4:0] HORIZONTAL_FRONT_PORCH  = 5'h01;
  localparam logic [4:0] HORIZONTAL_SYNC_END     = 5'h02;
  localparam logic [4:0] HORIZONTAL_BLANK_WIDTH  = 5'h03;
  localparam logic [4:0] CLOCKS_PER_LINE         = 5'h04;
  localparam logic [4:0] VERTICAL_FRONT_PORCH    = 5'h05;
  localparam logic [4:0] VERTICAL_SYNC_END       = 5'h06;
  localparam logic [4:0] VERTICAL_BLANK_WIDTH    = 5'h07;
  localparam logic [4:0] LINES_PER_FRAME         = 5'h08;
  localparam logic [4:0] EQUALIZATION_PULSE_END  = 5'h09;
  localparam logic [4:0] SERRATION_PULSE_END     = 5'h0a;
  localparam logic [4:0] EQ_SERR_INTERVAL_START  = 5'h0b;
  localparam logic [4:0] EQ_SERR_INTERVAL_END    = 5'h0c;
  localparam logic [4:0] VERT_INTERRUPT_ON_LINE  = 5'h0d;
  localparam logic [4:0] VERT_INTERRUPT_OFF_LINE = 5'h0e;
  localparam logic [4:0] HORIZ_CURSOR_START      = 5'h0f;
  localparam logic [4:0] HORIZ_CURSOR_END        = 5'h10;
  localparam logic [4:0] VERT_CURSOR_START       = 5'h11;
  localparam logic [4:0] VERT_CURSOR_END         = 5'h12;
  // status field positions
  localparam int unsigned ST_SEL_VERTICAL_BLANK = 0;
  localparam int unsigned ST_SEL_VSYNC  = 1;
  localparam int unsigned ST_SEL_CURSOR = 2;
  localparam int unsigned ST_MODE_LO    = 3;
  localparam int unsigned ST_MODE_HI    = 4;
  localparam int unsigned ST_POL_BLANK  = 5;
  localparam int unsigned ST_POL_SYNC   = 6;
  localparam int unsigned ST_POL_HBL    = 7;
  localparam int unsigned ST_POL_HSV    = 8;
  localparam int unsigned ST_EQ_OFF     = 9;
  localparam int unsigned ST_CLK_RUN    = 10;
  localparam int unsigned ST_TEST       = 11;
  // reset values
  localparam logic [11:0] STATUS_RST_BASE = 12'h000;
  localparam logic [11:0] STATUS_RST_RUN  = 12'h400;
  localparam logic [11:0] DATA_RST        = 12'h000;
  localparam logic [12:0] CNT_START       = 13'h0001;
  // mode codes in status bits 4:3
  localparam logic [1:0] MODE_INTERLACED = 2'h0;
  localparam logic [1:0] MODE_NI_DOUBLE  = 2'h1;
  localparam logic [1:0] MODE_ILLEGAL    = 2'h2;
  localparam logic [1:0] MODE_NI_SINGLE  = 2'h3;

  // one register write taken from the load pins
  typedef struct packed {
    logic [4:0]  addr;
    logic [11:0] data;
  } pvs_wr_t;

  // active-high timing terms before mapping and polarity
  typedef struct packed {
    logic horizontal_blank;
    logic hsync;
    logic vertical_blank;
    logic vsync;
    logic composite_blank;
    logic composite_sync;
    logic horizontal_gate;
    logic vertical_gate;
    logic cursor;
    logic vertical_interrupt;
  } pvs_terms_t;
endpackage

// File: hdl/pvs_timing.sv
`timescale 1ns/1ps
// Summary of operation
// R1: all registers twelve bits, pulses by start/end
// R2: status clears to zero, or 0x400 variant
// R3: status bits 0-2 select four output contents
// R4: bits 4:3 pick interlace/serration mode, 10 illegal
// R5: double modes pulse twice per line, single once
// R6: bits 5-8 set output polarities, one is high
// R7: bit 9 one suppresses equalization and serration
// R8: bit 10 stops or runs all timing
// R9: bit 11 factory counter test, keep zero
// R10: horizontal count 1 to clocks-per-line, falling edge
// R11: clocks-per-line must be programmed even
// R12: front porch, sync and blank from counts
// R13: vertical count 1 to lines-per-frame
// R14: interlaced vertical edges count half-lines
// R15: vertical porch, sync, blank from counts
// R16: vertical edges align with horizontal leading edges
// R17: composite terms are OR of active-high parts
// R18: eq/serration span between interval start/end
// R19: eq and serration widths from pulse end regs
// R20: gating pulses from cursor start/end registers
// R21: cursor is AND of horizontal, vertical gates
// R22: vertical interrupt between on and off lines
// R23: field high odd, low even, high non-interlaced
// R24: clear loads defaults, restarts counters
// R25: counters wrap to 1, field follows frame
module pvs_timing #(
  parameter bit RUN_AT_CLEAR = 1'b0  // variant that starts with timing running
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  // register load pins, asynchronous to clk_i
  input  wire logic        load_i,
  input  wire logic [4:0]  load_addr_i,
  input  wire logic [11:0] load_data_i,
  // video outputs
  output logic             vert_or_composite_blank_out_o,
  output logic             vert_or_composite_sync_out_o,
  output logic             horizontal_blank_or_hdrive_out_o,
  output logic             hsync_or_vdrive_out_o,
  output logic             field_odd_o
);

  localparam logic [11:0] STATUS_RST = RUN_AT_CLEAR ? pvs_pkg::STATUS_RST_RUN
                                                    : pvs_pkg::STATUS_RST_BASE;

  logic [11:0]          regs_r [pvs_pkg::REG_NUM];  // register file
  logic [2:0]           load_s_r;                   // load strobe sync chain
  pvs_pkg::pvs_wr_t     wr_s1_r;                    // first stage of pin sync
  pvs_pkg::pvs_wr_t     wr_s2_r;                    // settled address and data
  logic [12:0]          hcnt_r;                     // clock in line, from 1
  logic [12:0]          vcnt_r;                     // line or half-line unit, from 1
  logic                 vsync_r;                    // vertical sync aligned to hsync
  pvs_pkg::pvs_terms_t  t;                          // active-high timing terms
  logic                 blank_out_r;
  logic                 sync_out_r;
  logic                 hbl_out_r;
  logic                 hsv_out_r;
  logic                 field_r;

  // range test used by every start/end comparator but the serration gap
  function automatic logic in_span(input logic [12:0] cnt, input logic [11:0] lo,
                                   input logic [11:0] hi);
    in_span = (cnt >= {1'b0, lo}) && (cnt < {1'b0, hi});
  endfunction

  // status fields
  wire logic [11:0] status     = regs_r[pvs_pkg::STATUS_MODE_CONTROL];
  wire logic [1:0]  mode       = status[pvs_pkg::ST_MODE_HI:pvs_pkg::ST_MODE_LO];  // R4
  wire logic        interlaced = (mode == pvs_pkg::MODE_INTERLACED);
  // the illegal code behaves as single serration; software must avoid it
  wire logic        double_rate = (mode == pvs_pkg::MODE_INTERLACED) ||
                                  (mode == pvs_pkg::MODE_NI_DOUBLE);  // R5
  wire logic        run        = status[pvs_pkg::ST_CLK_RUN];  // R8
  wire logic        eq_on      = !status[pvs_pkg::ST_EQ_OFF];  // R7
  // bit 11 is stored only: the factory counter test is not built (R9)

  // line geometry; an odd clocks-per-line loses its low bit when halved (R11)
  wire logic [12:0] line_length_count   = {1'b0, regs_r[pvs_pkg::CLOCKS_PER_LINE]};
  wire logic [12:0] half   = {2'b00, regs_r[pvs_pkg::CLOCKS_PER_LINE][11:1]};
  wire logic        h_wrap = (hcnt_r >= line_length_count);
  wire logic        h_mid  = (hcnt_r == half);
  // whole frame in vertical units: half-lines when interlaced (R13)
  wire logic [12:0] frame_length_count   = interlaced ? {regs_r[pvs_pkg::LINES_PER_FRAME], 1'b0}
                                        : {1'b0, regs_r[pvs_pkg::LINES_PER_FRAME]};  // R14
  wire logic        v_step = h_wrap || (interlaced && h_mid);
  wire logic        v_wrap = (vcnt_r >= frame_length_count);

  // position inside the current eq/serration period
  wire logic [12:0] hpos   = (double_rate && (hcnt_r > half)) ? hcnt_r - half : hcnt_r;
  wire logic [11:0] r_hfp  = regs_r[pvs_pkg::HORIZONTAL_FRONT_PORCH];
  wire logic        hs_start = (hpos == {1'b0, r_hfp});

  // pin synchroniser; logic reads the second data stage and strobe stages two and three
  always_ff @(negedge clk_i) begin
    load_s_r <= {load_s_r[1:0], load_i};
    wr_s1_r  <= '{addr: load_addr_i, data: load_data_i};
    wr_s2_r  <= wr_s1_r;
  end

  wire logic load_rise = load_s_r[1] && !load_s_r[2];

  // register file: a load rising edge writes one whole register (R1)
  genvar gi;
  generate
    for (gi = 0; gi < pvs_pkg::REG_NUM; gi++) begin : g_reg
      localparam logic [11:0] RST = (gi == 0) ? STATUS_RST : pvs_pkg::DATA_RST;
      always_ff @(negedge clk_i) begin
        if (srst_i) begin
          regs_r[gi] <= RST;  // R2 R24
        end else if (load_rise && (wr_s2_r.addr == 5'(gi))) begin
          regs_r[gi] <= wr_s2_r.data;
        end
      end
    end
  endgenerate

  // horizontal and vertical counters; held while timing is stopped
  always_ff @(negedge clk_i) begin
    if (srst_i) begin
      hcnt_r <= pvs_pkg::CNT_START;  // R24
      vcnt_r <= pvs_pkg::CNT_START;
    end else if (run) begin  // R8
      hcnt_r <= h_wrap ? pvs_pkg::CNT_START : hcnt_r + 13'h0001;  // R10 R25
      if (v_step) begin
        vcnt_r <= v_wrap ? pvs_pkg::CNT_START : vcnt_r + 13'h0001;  // R13 R25
      end
    end
  end

  // vertical sync window in the current vertical unit
  wire logic vsync_now = in_span(vcnt_r, regs_r[pvs_pkg::VERTICAL_FRONT_PORCH],
                                 regs_r[pvs_pkg::VERTICAL_SYNC_END]);  // R15
  wire logic vs_take   = run && hs_start;  // a horizontal sync leading edge, or the mid-line point in double rate modes

  // vertical sync changes only at a horizontal sync leading edge or, in double rate modes, at the mid-line point
  always_ff @(negedge clk_i) begin
    if (srst_i) begin
      vsync_r <= 1'b0;
    end else if (vs_take) begin
      vsync_r <= vsync_now;  // R15 R16
    end
  end

  // timing terms, all active high
  wire logic eq_span = in_span(vcnt_r, regs_r[pvs_pkg::EQ_SERR_INTERVAL_START],
                               regs_r[pvs_pkg::EQ_SERR_INTERVAL_END]);  // R18
  wire logic eq_pulse = in_span(hpos, r_hfp, regs_r[pvs_pkg::EQUALIZATION_PULSE_END]);  // R19
  // serration: sync held except the gap from front porch to serration end
  wire logic serr_pulse = (hpos >= {1'b0, regs_r[pvs_pkg::SERRATION_PULSE_END]}) ||
                          (hpos < {1'b0, r_hfp});  // R19
  always_comb begin
    t.horizontal_blank = in_span(hcnt_r, 12'h001, regs_r[pvs_pkg::HORIZONTAL_BLANK_WIDTH]);  // R12
    t.hsync  = in_span(hcnt_r, r_hfp, regs_r[pvs_pkg::HORIZONTAL_SYNC_END]);  // R12
    // vertical counter moves at line start, the horizontal_blank leading edge
    t.vertical_blank = in_span(vcnt_r, 12'h001, regs_r[pvs_pkg::VERTICAL_BLANK_WIDTH]);  // R15 R16
    // bypass at the sync edge so vsync leaves in the same clock as hsync
    t.vsync  = vs_take ? vsync_now : vsync_r;  // R16
    t.composite_blank = t.horizontal_blank || t.vertical_blank;  // R17
    if (eq_on && eq_span) begin
      t.composite_sync = t.vsync ? serr_pulse : eq_pulse;  // R18
    end else begin
      t.composite_sync = t.hsync || t.vsync;  // R17
    end
    t.horizontal_gate  = in_span(hcnt_r, regs_r[pvs_pkg::HORIZ_CURSOR_START],
                       regs_r[pvs_pkg::HORIZ_CURSOR_END]);  // R20
    t.vertical_gate  = in_span(vcnt_r, regs_r[pvs_pkg::VERT_CURSOR_START],
                       regs_r[pvs_pkg::VERT_CURSOR_END]);  // R20
    t.cursor = t.horizontal_gate && t.vertical_gate;  // R21
    t.vertical_interrupt   = in_span(vcnt_r, regs_r[pvs_pkg::VERT_INTERRUPT_ON_LINE],
                       regs_r[pvs_pkg::VERT_INTERRUPT_OFF_LINE]);  // R22
  end

  // output selection per status bits 0-2
  wire logic sel_blank = status[pvs_pkg::ST_SEL_VERTICAL_BLANK] ? t.vertical_blank : t.composite_blank;  // R3
  wire logic sel_sync  = status[pvs_pkg::ST_SEL_VSYNC] ? t.vsync : t.composite_sync;  // R3
  wire logic sel_hbl   = status[pvs_pkg::ST_SEL_VERTICAL_BLANK] ? t.horizontal_blank :
                         (status[pvs_pkg::ST_SEL_CURSOR] ? t.cursor : t.horizontal_gate);  // R3
  wire logic sel_hsv   = status[pvs_pkg::ST_SEL_VSYNC] ? t.hsync :
                         (status[pvs_pkg::ST_SEL_CURSOR] ? t.vertical_interrupt : t.vertical_gate);  // R3
  // field: first half of an interlaced frame is odd
  wire logic field_nxt = !interlaced || (vcnt_r <= {1'b0, regs_r[pvs_pkg::LINES_PER_FRAME]});

  // registered outputs; a zero polarity bit gives active low
  always_ff @(negedge clk_i) begin
    if (srst_i) begin
      blank_out_r <= 1'b0;
      sync_out_r  <= 1'b0;
      hbl_out_r   <= 1'b0;
      hsv_out_r   <= 1'b0;
      field_r     <= 1'b1;
    end else begin
      blank_out_r <= sel_blank ^ !status[pvs_pkg::ST_POL_BLANK];  // R6
      sync_out_r  <= sel_sync ^ !status[pvs_pkg::ST_POL_SYNC];  // R6
      hbl_out_r   <= sel_hbl ^ !status[pvs_pkg::ST_POL_HBL];  // R6
      hsv_out_r   <= sel_hsv ^ !status[pvs_pkg::ST_POL_HSV];  // R6
      field_r     <= field_nxt;  // R23
    end
  end

  assign vert_or_composite_blank_out_o = blank_out_r;
  assign vert_or_composite_sync_out_o  = sync_out_r;
  assign horizontal_blank_or_hdrive_out_o        = hbl_out_r;
  assign hsync_or_vdrive_out_o         = hsv_out_r;
  assign field_odd_o                   = field_r;

  // checks
  chk_hcnt_range: assert property (@(negedge clk_i) disable iff (srst_i)  // R10
    (hcnt_r != 13'h0000)) else $error("horizontal count left its range");
  chk_hcnt_wrap: assert property (@(negedge clk_i) disable iff (srst_i)  // R25
    (run && h_wrap) |=> (hcnt_r == pvs_pkg::CNT_START))
    else $error("horizontal count did not return to one");
  chk_stop_hold: assert property (@(negedge clk_i) disable iff (srst_i)  // R8
    (!run && !load_rise) |=> $stable(hcnt_r) && $stable(vcnt_r))
    else $error("counters moved while stopped");
  chk_vstep_line: assert property (@(negedge clk_i) disable iff (srst_i)  // R13
    (run && !interlaced && !h_wrap && !v_wrap) |=> $stable(vcnt_r))
    else $error("vertical count moved mid line");
  chk_composite_sync_or: assert property (@(negedge clk_i) disable iff (srst_i)  // R17
    (!eq_span || !eq_on) |-> (t.composite_sync == (t.hsync || t.vsync)))
    else $error("composite sync not an OR");
  chk_composite_blank_or: assert property (@(negedge clk_i) disable iff (srst_i)  // R17
    t.composite_blank == (t.horizontal_blank || t.vertical_blank)) else $error("composite blank not an OR");
  chk_blank_pol: assert property (@(negedge clk_i) disable iff (srst_i)  // R6
    !$past(srst_i) |->
    (blank_out_r == ($past(sel_blank) ^ !$past(status[pvs_pkg::ST_POL_BLANK]))))
    else $error("blank output polarity wrong");
  chk_field_ni: assert property (@(negedge clk_i) disable iff (srst_i)  // R23
    (!interlaced && $past(!interlaced)) |-> field_odd_o)
    else $error("field output low outside interlace");
  chk_vsync_edge: assert property (@(negedge clk_i) disable iff (srst_i)  // R16
    !$past(run && hs_start) |-> $stable(vsync_r))
    else $error("vertical sync moved off a sync edge");
  chk_cursor_and: assert property (@(negedge clk_i) disable iff (srst_i)  // R21
    t.cursor |-> (t.horizontal_gate && t.vertical_gate)) else $error("cursor outside gates");
  chk_status_reset: assert property (@(negedge clk_i)  // R2
    srst_i |=> (status == STATUS_RST)) else $error("status reset value wrong");

endmodule

// File: test/pvs_sync_rx.sv
`timescale 1ns/1ps
// sync receiver model: times the edges of the four video lines and the field line
module pvs_sync_rx (
  // clock and measurement restart
  input  wire logic        clk_i,
  input  wire logic        clr_i,
  // active level of each line, then the lines
  input  wire logic [4:0]  lvl_i,
  input  wire logic [4:0]  sig_i,
  // figures per line, in clocks, and the stamp of the last start
  output logic      [31:0] per_o  [5],
  output logic      [31:0] minp_o [5],
  output logic      [31:0] wid_o  [5],
  output logic      [31:0] minw_o [5],
  output logic      [31:0] maxw_o [5],
  output logic      [31:0] rise_o [5]
);
  logic [31:0] now_r = 32'h0;  // free clock count used as a time stamp
  logic [4:0]  act_d = 5'h00;  // active state one clock ago
  logic [4:0]  seen  = 5'h00;  // a start was seen since the last restart
  wire  [4:0]  act   = ~(sig_i ^ lvl_i);  // polarity taken out

  // sample on the rising edge, half a cycle after the block moves its lines
  always @(posedge clk_i) begin
    now_r <= now_r + 32'h1;
    act_d <= act;
    for (int i = 0; i < 5; i++) begin
      if (clr_i) begin
        // partial pulses before a restart are not trusted
        seen[i]   <= 1'b0;
        minp_o[i] <= 32'hffffffff;
        minw_o[i] <= 32'hffffffff;
        maxw_o[i] <= 32'h0;
      end else if (act[i] && !act_d[i]) begin
        seen[i]   <= 1'b1;
        rise_o[i] <= now_r;
        if (seen[i]) begin
          per_o[i]  <= now_r - rise_o[i];
          minp_o[i] <= (now_r - rise_o[i] < minp_o[i]) ? now_r - rise_o[i] : minp_o[i];
        end
      end else if (!act[i] && act_d[i] && seen[i]) begin
        wid_o[i]  <= now_r - rise_o[i];
        minw_o[i] <= (now_r - rise_o[i] < minw_o[i]) ? now_r - rise_o[i] : minw_o[i];
        maxw_o[i] <= (now_r - rise_o[i] > maxw_o[i]) ? now_r - rise_o[i] : maxw_o[i];
      end
    end
  end
endmodule

// File: test/tb_top.sv
`timescale 1ns/1ps
// bench: programs the timing block and compares measured pulse figures
module tb_top;
  // clock, clear and load pins
  logic        clk_i       = 1'b0;
  logic        srst_i      = 1'b1;
  logic        load_i      = 1'b0;
  logic [4:0]  load_addr_i = 5'h00;
  logic [11:0] load_data_i = 12'h000;
  // video lines: blank, sync, hbl/drive, hsync/drive, field
  wire  [4:0]  vid;
  logic [4:0]  snap;
  // receiver control and figures
  logic        rx_clr = 1'b1;
  logic [4:0]  rx_lvl = 5'h1f;
  logic [31:0] per [5];
  logic [31:0] minp [5];
  logic [31:0] wid [5];
  logic [31:0] minw [5];
  logic [31:0] maxw [5];
  logic [31:0] rise [5];
  int          err_count       = 0;
  int          samples_checked = 0;
  // small even line of 20 clocks and 12 lines, so one frame is 240 clocks
  logic [11:0] regs [19] = '{12'h000, 12'h004, 12'h007, 12'h006, 12'h014, 12'h004,
                             12'h006, 12'h005, 12'h00c, 12'h006, 12'h008, 12'h002,
                             12'h008, 12'h003, 12'h005, 12'h008, 12'h00b, 12'h002,
                             12'h004};

  always #25 clk_i = ~clk_i;

  pvs_timing #(.RUN_AT_CLEAR(1'b0)) uut (
    .clk_i                         (clk_i),
    .srst_i                        (srst_i),
    .load_i                        (load_i),
    .load_addr_i                   (load_addr_i),
    .load_data_i                   (load_data_i),
    .vert_or_composite_blank_out_o (vid[0]),
    .vert_or_composite_sync_out_o  (vid[1]),
    .horizontal_blank_or_hdrive_out_o        (vid[2]),
    .hsync_or_vdrive_out_o         (vid[3]),
    .field_odd_o                   (vid[4])
  );

  pvs_sync_rx rx (
    .clk_i  (clk_i),
    .clr_i  (rx_clr),
    .lvl_i  (rx_lvl),
    .sig_i  (vid),
    .per_o  (per),
    .minp_o (minp),
    .wid_o  (wid),
    .minw_o (minw),
    .maxw_o (maxw),
    .rise_o (rise)
  );

  // verdict and end of run, shared by the sequence and the watchdog
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // one comparison of a measured figure
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one full-word load; held three clocks so the synchroniser sees it
  task automatic wr(input logic [4:0] a, input logic [11:0] d);
    @(negedge clk_i);
    load_addr_i <= a;
    load_data_i <= d;
    load_i      <= 1'b1;
    repeat (3) @(negedge clk_i);
    load_i <= 1'b0;
    repeat (3) @(negedge clk_i);
  endtask

  // new status, settle, restart the receiver, then watch over two frames
  task automatic run(input logic [11:0] st, input logic [4:0] lv);
    wr(5'h00, st);
    rx_lvl <= lv;
    repeat (300) @(negedge clk_i);
    rx_clr <= 1'b1;
    @(negedge clk_i);
    rx_clr <= 1'b0;
    repeat (600) @(negedge clk_i);
  endtask

  // distance from stamp b to stamp a, folded into one period m
  function automatic logic [31:0] md(input logic [31:0] a, input logic [31:0] b,
                                     input logic [31:0] m);
    return ((a % m) + m - (b % m)) % m;
  endfunction

  // watchdog: the sequence needs about 7000 clocks
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    conclude();
  end

  initial begin
    repeat (3) @(negedge clk_i);
    srst_i <= 1'b0;
    // outputs still hold their cleared values until the next falling edge
    @(posedge clk_i);
    cmp({31'h0, vid[4]}, 32'h1);
    @(negedge clk_i);
    @(posedge clk_i);
    snap = vid;
    repeat (50) @(posedge clk_i);
    cmp({27'h0, vid}, {27'h0, snap});
    @(negedge clk_i);
    // data registers; line length kept even for the half-line modes
    for (int i = 1; i < 19; i++) wr(i[4:0], regs[i]);
    // separate outputs, all active high, non-interlaced single rate
    run(12'h5fb, 5'h1f);
    cmp(per[2], 32'd20);
    cmp(wid[2], 32'd5);
    cmp(wid[3], 32'd3);
    cmp(md(rise[3], rise[2], 32'd20), 32'd3);
    cmp(per[0], 32'd240);
    cmp(wid[0], 32'd80);
    cmp(wid[1], 32'd40);
    // three lines of porch plus the hsync offset, since vsync follows hsync
    cmp(md(rise[1], rise[0], 32'd240), 32'd63);
    cmp(md(rise[1], rise[3], 32'd20), 32'd0);
    cmp(md(rise[0], rise[2], 32'd20), 32'd0);
    cmp({31'h0, vid[4]}, 32'h1);
    // same timing with the four lines active low
    run(12'h41b, 5'h10);
    cmp(wid[2], 32'd5);
    cmp(wid[1], 32'd40);
    // interlaced: vertical counts are half-lines, field flips each half frame
    run(12'h5e3, 5'h1f);
    cmp(wid[4], 32'd120);
    cmp(per[4], 32'd240);
    cmp(wid[0], 32'd40);
    // composite with equalization off, gating on the drive lines
    run(12'h7f8, 5'h1f);
    cmp(maxw[1], 32'd43);
    cmp(minp[1], 32'd20);
    cmp(maxw[0], 32'd85);
    cmp(wid[2], 32'd3);
    cmp(wid[3], 32'd40);
    cmp(per[3], 32'd240);
    // composite with equalization, double rate
    run(12'h5e8, 5'h1f);
    cmp(minp[1], 32'd10);
    cmp(minw[1], 32'd2);
    // single rate equalization, then cursor and vertical interrupt
    run(12'h5f8, 5'h1f);
    cmp(minp[1], 32'd20);
    cmp(minw[1], 32'd2);
    run(12'h5fc, 5'h1f);
    cmp(maxw[2], 32'd3);
    cmp(wid[3], 32'd40);
    cmp(per[3], 32'd240);
    cmp(md(rise[3], rise[0], 32'd20), 32'd0);
    conclude();
  end
endmodule
